// ==== common/stn_pkg.sv ====
// shared constants, types and helpers for the stn panel timing and video path
package stn_pkg;
  typedef enum logic [2:0] {STN_MONO, STN_GRAY4, STN_GRAY16, STN_COL256, STN_COL4096} stn_color_type;
  typedef enum logic [1:0] {STN_SCAN4, STN_DUAL4, STN_SCAN8} stn_scan_type;

  localparam int          STN_FIFO_DEPTH = 8;
  localparam int          STN_WORD_W     = 12;
  localparam logic [2:0]  STN_PULSE_EXP  = 3'h4;
  localparam int          STN_BLANK_SHL  = 3;
  localparam logic [3:0]  STN_LANES_NARROW = 4'h4;
  localparam logic [3:0]  STN_LANES_WIDE   = 4'h8;
  localparam logic [3:0]  STN_MONO_BITS  = 4'h8;
  localparam logic [3:0]  STN_COLOR_BITS = 4'h3;
  localparam logic [3:0]  STN_LEVEL_FULL = 4'hf;
  localparam logic [4:0]  STN_BUF_LOW    = 5'h08;
  localparam logic [15:0] STN_BUF_RESET  = 16'h0000;

  // 2^(4+sel) bus clocks, shared by sync width and delay
  function automatic logic [10:0] stn_pulse_len(input logic [1:0] sel);
    stn_pulse_len = 11'h001 << (STN_PULSE_EXP + {1'b0, sel});
  endfunction

  function automatic logic [3:0] stn_nibble(input logic [31:0] v, input logic [2:0] i);
    stn_nibble = v[{i, 2'b00} +: 4];
  endfunction

  // frame rate modulation: level/16 on-duty over 16 phases, full level always on
  function automatic logic stn_dither(input logic [3:0] level, input logic [3:0] phase);
    logic [7:0] prod;
    prod = {4'h0, level} * {4'h0, phase};
    stn_dither = (level == STN_LEVEL_FULL) | ((5'(prod[3:0]) + 5'(level)) > 5'h0f);
  endfunction
endpackage

// ==== common/stn_stream_if.sv ====
// valid/ready word stream between the video path modules
`timescale 1ns/1ps
interface stn_stream_if #(
  parameter int W = 12
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (
    output valid,
    output data,
    input  ready
  );
  modport snk (
    input  valid,
    input  data,
    output ready
  );
endinterface

// ==== src/stn_fifo.sv ====
// small video fifo with a registered output stage
`timescale 1ns/1ps
module stn_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input logic      clk,
  input logic      resetn,
  // streams
  stn_stream_if.snk in_s,
  stn_stream_if.src out_s
);
  import stn_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } stn_fifo_state_type;

  stn_fifo_state_type q, d;
  logic push;
  logic load;

  assign in_s.ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = q.ov;
  assign out_s.data  = q.od;

  always_comb begin
    d = q;
    push = in_s.valid && in_s.ready;
    // refill the output register whenever it is empty or being taken
    load = (!q.ov || out_s.ready) && (q.cnt != '0);
    if (push) begin
      d.mem[q.wr] = in_s.data;
      d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (load) begin
      d.od = q.mem[q.rd];
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      d.ov = 1'b1;
    end else if (out_s.ready) begin
      d.ov = 1'b0;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ==== src/stn_pal.sv ====
// per-pixel palette lookup and dithering, yields the bits a pixel contributes
`timescale 1ns/1ps
module stn_pal (
  // configuration
  input stn_pkg::stn_color_type color_mode,
  input logic [31:0]            red_palette_reg,
  input logic [31:0]            green_palette_reg,
  input logic [15:0]            blue_palette_reg,
  // pixel in
  input logic [11:0]            pixel,
  input logic [3:0]             phase,
  // bits out, msb first
  output logic [7:0]            bits,
  output logic [3:0]            nbits
);
  import stn_pkg::*;
  logic [31:0] blue_ext;
  logic [3:0]  r_lvl;
  logic [3:0]  g_lvl;
  logic [3:0]  b_lvl;

  assign blue_ext = {16'h0000, blue_palette_reg};

  always_comb begin
    r_lvl = 4'h0;
    g_lvl = 4'h0;
    b_lvl = 4'h0;
    bits  = 8'h00;
    nbits = 4'h1;
    unique case (color_mode)
      STN_MONO: begin
        bits  = pixel[7:0];
        nbits = STN_MONO_BITS;
      end
      STN_GRAY4: begin
        b_lvl = stn_nibble(blue_ext, {1'b0, pixel[1:0]});
        bits  = {stn_dither(b_lvl, phase), 7'h00};
      end
      STN_GRAY16: begin
        bits = {stn_dither(pixel[3:0], phase), 7'h00};
      end
      STN_COL256: begin
        r_lvl = stn_nibble(red_palette_reg, pixel[7:5]);
        g_lvl = stn_nibble(green_palette_reg, pixel[4:2]);
        b_lvl = stn_nibble(blue_ext, {1'b0, pixel[1:0]});
      end
      STN_COL4096: begin
        r_lvl = pixel[11:8];
        g_lvl = pixel[7:4];
        b_lvl = pixel[3:0];
      end
      default: begin
        bits = 8'h00;
      end
    endcase
    if (color_mode == STN_COL256 || color_mode == STN_COL4096) begin
      // offset phases so the three subpixels do not flash together
      bits  = {stn_dither(r_lvl, phase), stn_dither(g_lvl, phase + 4'h5),
               stn_dither(b_lvl, phase + 4'ha), 5'h00};
      nbits = STN_COLOR_BITS;
    end
  end
endmodule

// ==== src/stn_lcd_timing.sv ====
// stn panel timing generator and pixel serializer
// Notes on behaviour
// - frame sync is high for the entire first line, once per frame
// - bias select 0: ac bias inverts once every frame
// - bias select 1: ac bias inverts after every bias line count line syncs
// - four data lines in 4-bit single scan, four per half (eight) in 4-bit dual, eight in 8-bit single
// - line count field is lines per scanned half, minus one
// - pixel clock period is twice the divider in bus clocks, divider 2..1023
// - line sync lasts 2^(4+width sel), then 2^(4+delay sel) clocks of delay
// - a line is width+1 pixel periods, sync, delay, blank*8; frame is count+1 lines
// - monochrome bypasses palette and modulation, shifting raw bits out
// - gray and colour levels use dithering with frame rate modulation
// - 4-level gray maps value n to nibble n of the blue palette
// - 16-level gray uses the pixel value directly as level
// - 256-colour splits a pixel into 3 red, 3 green, 2 blue index bits
// - red and green index i selects nibble i of its 32-bit palette
// - blue index selects one of four nibbles of the 16-bit blue palette
// - 4096-colour applies no palette
// - 4096-colour pixel holds 4 bits each of red, green, blue
// - data is clocked by pixel clock; line sync follows each full line
`timescale 1ns/1ps
module stn_lcd_timing (
  // clock and reset
  input  logic                  clk,
  input  logic                  resetn,
  // configuration
  input  logic                  enable,
  input  stn_pkg::stn_color_type color_mode,
  input  stn_pkg::stn_scan_type scan_mode,
  input  logic                  bias_toggle_select,
  input  logic [7:0]            bias_line_count,
  input  logic [10:0]           line_width_count,
  input  logic [9:0]            frame_line_count,
  input  logic [9:0]            pixel_clock_divider,
  input  logic [1:0]            sync_width_select,
  input  logic [1:0]            sync_delay_select,
  input  logic [7:0]            line_blank_count,
  input  logic [31:0]           red_palette_reg,
  input  logic [31:0]           green_palette_reg,
  input  logic [15:0]           blue_palette_reg,
  // video input, upper and lower halves
  input  logic                  upper_valid,
  output logic                  upper_ready,
  input  logic [11:0]           upper_data,
  input  logic                  lower_valid,
  output logic                  lower_ready,
  input  logic [11:0]           lower_data,
  // panel pins
  output logic                  frame_sync_out,
  output logic                  line_sync_out,
  output logic                  pixel_clock_out,
  output logic                  ac_bias_out,
  output logic [7:0]            pixel_data_bus,
  // status
  output logic                  underrun_pulse
);
  import stn_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ACTIVE, ST_SYNC, ST_DELAY, ST_BLANK} stn_tstate_type;

  typedef struct packed {
    stn_tstate_type st;
    logic [9:0]     div;
    logic [10:0]    tcnt;
    logic [10:0]    beat;
    logic [9:0]     line;
    logic           pclk;
    logic           fsync;
    logic           lsync;
    logic           bias;
    logic [7:0]     bcnt;
    logic [3:0]     frame;
    logic [15:0]    ubuf;
    logic [4:0]     ucnt;
    logic [15:0]    lbuf;
    logic [4:0]     lcnt;
    logic [3:0]     upos;
    logic [3:0]     lpos;
    logic [7:0]     data;
    logic           urun;
  } stn_core_type;

  stn_core_type q, d;

  stn_stream_if #(.W(STN_WORD_W)) up_in ();
  stn_stream_if #(.W(STN_WORD_W)) up_out ();
  stn_stream_if #(.W(STN_WORD_W)) lo_in ();
  stn_stream_if #(.W(STN_WORD_W)) lo_out ();

  logic [7:0] u_bits;
  logic [3:0] u_nbits;
  logic [7:0] l_bits;
  logic [3:0] l_nbits;
  logic       upop;
  logic       lpop;

  assign up_in.valid    = upper_valid;
  assign up_in.data     = upper_data;
  assign upper_ready    = up_in.ready;
  assign lo_in.valid    = lower_valid;
  assign lo_in.data     = lower_data;
  assign lower_ready    = lo_in.ready;
  assign up_out.ready   = upop;
  assign lo_out.ready   = lpop;

  stn_fifo #(.WIDTH(STN_WORD_W), .DEPTH(STN_FIFO_DEPTH)) u_fifo_upper (
    .clk    (clk),
    .resetn (resetn),
    .in_s   (up_in),
    .out_s  (up_out)
  );

  stn_fifo #(.WIDTH(STN_WORD_W), .DEPTH(STN_FIFO_DEPTH)) u_fifo_lower (
    .clk    (clk),
    .resetn (resetn),
    .in_s   (lo_in),
    .out_s  (lo_out)
  );

  stn_pal u_pal_upper (
    .color_mode        (color_mode),
    .red_palette_reg   (red_palette_reg),
    .green_palette_reg (green_palette_reg),
    .blue_palette_reg  (blue_palette_reg),
    .pixel             (up_out.data),
    .phase             (q.frame + q.upos),
    .bits              (u_bits),
    .nbits             (u_nbits)
  );

  stn_pal u_pal_lower (
    .color_mode        (color_mode),
    .red_palette_reg   (red_palette_reg),
    .green_palette_reg (green_palette_reg),
    .blue_palette_reg  (blue_palette_reg),
    .pixel             (lo_out.data),
    .phase             (q.frame + q.lpos),
    .bits              (l_bits),
    .nbits             (l_nbits)
  );

  // take bits off the head of a buffer, then append new bits behind what is left
  function automatic logic [20:0] stn_ser_step(input logic [15:0] b, input logic [4:0] c,
                                               input logic [3:0] take, input logic [7:0] bits,
                                               input logic [3:0] nb);
    logic [15:0] nbuf;
    logic [4:0]  ncnt;
    nbuf = b << take;
    ncnt = (c > 5'(take)) ? c - 5'(take) : 5'h00;
    nbuf = nbuf | ({bits, 8'h00} >> ncnt);
    ncnt = ncnt + 5'(nb);
    stn_ser_step = {nbuf, ncnt};
  endfunction

  assign frame_sync_out  = q.fsync;
  assign line_sync_out   = q.lsync;
  assign pixel_clock_out = q.pclk;
  assign ac_bias_out     = q.bias;
  assign pixel_data_bus  = q.data;
  assign underrun_pulse  = q.urun;

  always_comb begin
    logic        load_beat;
    logic        end_line;
    logic        dual;
    logic [3:0]  ulanes;
    logic [3:0]  utake;
    logic [3:0]  ltake;
    logic [20:0] ustep;
    logic [20:0] lstep;
    load_beat = 1'b0;
    end_line  = 1'b0;
    dual      = (scan_mode == STN_DUAL4);
    ulanes    = (scan_mode == STN_SCAN8) ? STN_LANES_WIDE : STN_LANES_NARROW;
    d         = q;
    d.urun    = 1'b0;
    utake     = 4'h0;
    ltake     = 4'h0;
    ustep     = '0;
    lstep     = '0;
    unique case (q.st)
      ST_IDLE: begin
        if (enable) begin
          d.st    = ST_ACTIVE;
          d.line  = 10'h000;
          d.beat  = 11'h000;
          d.div   = 10'h000;
          d.fsync = 1'b1;
          load_beat = 1'b1;
        end
      end
      ST_ACTIVE: begin
        if (q.div == pixel_clock_divider - 10'h001) begin
          d.div  = 10'h000;
          d.pclk = !q.pclk;
          if (q.pclk) begin
            if (q.beat == line_width_count) begin
              d.st    = ST_SYNC;
              d.tcnt  = 11'h000;
              d.lsync = 1'b1;
            end else begin
              d.beat    = q.beat + 11'h001;
              load_beat = 1'b1;
            end
          end
        end else begin
          d.div = q.div + 10'h001;
        end
      end
      ST_SYNC: begin
        if (q.tcnt == stn_pulse_len(sync_width_select) - 11'h001) begin
          d.lsync = 1'b0;
          d.st    = ST_DELAY;
          d.tcnt  = 11'h000;
          if (bias_toggle_select) begin
            // a zero count behaves like one: invert at every line
            if ({1'b0, q.bcnt} + 9'h001 >= {1'b0, bias_line_count}) begin
              d.bcnt = 8'h00;
              d.bias = !q.bias;
            end else begin
              d.bcnt = q.bcnt + 8'h01;
            end
          end
        end else begin
          d.tcnt = q.tcnt + 11'h001;
        end
      end
      ST_DELAY: begin
        if (q.tcnt == stn_pulse_len(sync_delay_select) - 11'h001) begin
          d.tcnt = 11'h000;
          if (line_blank_count == 8'h00) begin
            end_line = 1'b1;
          end else begin
            d.st = ST_BLANK;
          end
        end else begin
          d.tcnt = q.tcnt + 11'h001;
        end
      end
      ST_BLANK: begin
        if (q.tcnt == (11'(line_blank_count) << STN_BLANK_SHL) - 11'h001) begin
          end_line = 1'b1;
        end else begin
          d.tcnt = q.tcnt + 11'h001;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    if (end_line) begin
      d.st   = ST_ACTIVE;
      d.beat = 11'h000;
      d.div  = 10'h000;
      d.tcnt = 11'h000;
      load_beat = 1'b1;
      if (q.line == frame_line_count) begin
        d.line  = 10'h000;
        d.fsync = 1'b1;
        d.frame = q.frame + 4'h1;
        d.upos  = 4'h0;
        d.lpos  = 4'h0;
        if (!bias_toggle_select) begin
          d.bias = !q.bias;
        end
        if (!enable) begin
          // stopping only at a frame boundary keeps the panel in step
          d.st      = ST_IDLE;
          d.fsync   = 1'b0;
          load_beat = 1'b0;
        end
      end else begin
        d.line  = q.line + 10'h001;
        d.fsync = 1'b0;
      end
    end
    // serializer: pops refill the bit buffers ahead of the next beat
    utake = load_beat ? ulanes : 4'h0;
    ltake = (load_beat && dual) ? STN_LANES_NARROW : 4'h0;
    // prefetch also while stopped, so the first beat after enable is not starved
    upop  = up_out.valid && (q.ucnt < STN_BUF_LOW);
    lpop  = dual && lo_out.valid && (q.lcnt < STN_BUF_LOW);
    if (load_beat) begin
      d.urun = (q.ucnt < 5'(ulanes)) || (dual && q.lcnt < 5'(STN_LANES_NARROW));
      unique case (scan_mode)
        STN_SCAN8: d.data = q.ubuf[15:8];
        STN_DUAL4: d.data = {q.ubuf[15:12], q.lbuf[15:12]};
        default:   d.data = {4'h0, q.ubuf[15:12]};
      endcase
    end
    ustep  = stn_ser_step(q.ubuf, q.ucnt, utake, upop ? u_bits : 8'h00,
                          upop ? u_nbits : 4'h0);
    lstep  = stn_ser_step(q.lbuf, q.lcnt, ltake, lpop ? l_bits : 8'h00,
                          lpop ? l_nbits : 4'h0);
    d.ubuf = ustep[20:5];
    d.ucnt = ustep[4:0];
    d.lbuf = lstep[20:5];
    d.lcnt = lstep[4:0];
    d.upos = d.upos + 4'(upop);
    d.lpos = d.lpos + 4'(lpop);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // helper counters that only the checks below read
  logic [10:0] hi_len_q;
  logic [10:0] sync_len_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_len_q   <= 11'h000;
      sync_len_q <= 11'h000;
    end else begin
      hi_len_q   <= pixel_clock_out ? hi_len_q + 11'h001 : 11'h000;
      sync_len_q <= line_sync_out ? sync_len_q + 11'h001 : 11'h000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_sync_end;
    $fell(line_sync_out);
  endsequence
  sequence s_new_frame;
    $rose(frame_sync_out) && $past(q.st) != ST_IDLE;
  endsequence

  AST_FSYNC_LINE0: assert property ($fell(frame_sync_out)
    |-> q.line == 10'h001 || q.st == ST_IDLE)
    else $error("frame sync dropped outside first line");
  AST_FRAME_LEN: assert property (s_new_frame |-> $past(q.line) == frame_line_count)
    else $error("frame ended at wrong line count");
  AST_BIAS_FRAME: assert property ((s_new_frame and !bias_toggle_select)
    |-> ac_bias_out != $past(ac_bias_out))
    else $error("ac bias did not invert at frame start");
  AST_BIAS_LINES: assert property (bias_toggle_select && $changed(ac_bias_out)
    |-> s_sync_end)
    else $error("ac bias changed away from a line sync end");
  AST_PCLK_HALF: assert property ($fell(pixel_clock_out)
    |-> hi_len_q == 11'(pixel_clock_divider))
    else $error("pixel clock high phase not equal to divider");
  AST_SYNC_WIDTH: assert property (s_sync_end
    |-> sync_len_q == stn_pulse_len(sync_width_select))
    else $error("line sync width wrong");
  AST_SYNC_AFTER_LINE: assert property ($rose(line_sync_out)
    |-> $past(q.beat) == line_width_count && $fell(pixel_clock_out))
    else $error("line sync not after last pixel period");
  AST_DELAY_QUIET: assert property (s_sync_end
    |-> (!pixel_clock_out && !line_sync_out)[*8])
    else $error("pixel clock active during sync delay");
  AST_PCLK_IDLE: assert property (q.st != ST_ACTIVE |-> !pixel_clock_out)
    else $error("pixel clock toggling outside active data");
  AST_NARROW_LANES: assert property (scan_mode == STN_SCAN4 && $past(scan_mode) == STN_SCAN4
    |-> pixel_data_bus[7:4] == 4'h0)
    else $error("unused data lanes driven in 4-bit single scan");
endmodule

// ==== bench/stn_panel_model.sv ====
// behavioural panel driver: samples the video bus and counts beats and lines
`timescale 1ns/1ps
module stn_panel_model (
  // panel pins
  input  wire logic        frame_sync_out,
  input  wire logic        line_sync_out,
  input  wire logic        pixel_clock_out,
  input  wire logic [7:0]  pixel_data_bus,
  // observations for the bench
  output logic      [7:0]  first_beat,
  output logic      [7:0]  second_beat,
  output logic      [11:0] beats_per_line,
  output logic      [11:0] lines_per_frame
);
  logic [11:0] beat_total = 12'h000;
  logic [11:0] beat_mark  = 12'h000;
  logic [11:0] line_total = 12'h000;
  logic [11:0] line_mark  = 12'h000;

  // the column shift register takes data on the rising pixel clock
  always @(posedge pixel_clock_out) begin
    if (beat_total == beat_mark)
      first_beat <= pixel_data_bus;
    if (beat_total == beat_mark + 12'h001)
      second_beat <= pixel_data_bus;
    beat_total <= beat_total + 12'h001;
  end

  // a line sync latches the shifted line; counts kept as running marks
  always @(posedge line_sync_out) begin
    beats_per_line <= beat_total - beat_mark;
    beat_mark      <= beat_total;
    line_total     <= line_total + 12'h001;
  end

  // frame sync returns the row pointer to the top
  always @(posedge frame_sync_out) begin
    lines_per_frame <= line_total - line_mark;
    line_mark       <= line_total;
  end
endmodule

// ==== bench/stn_lcd_timing_tb_top.sv ====
// self-checking bench for the stn panel timing generator and video path
`timescale 1ns/1ps
module stn_lcd_timing_tb_top;
  import stn_pkg::*;
  logic          clk                 = 1'b0;
  logic          resetn              = 1'b0;
  logic          enable              = 1'b0;
  stn_color_type color_mode          = STN_MONO;
  stn_scan_type  scan_mode           = STN_SCAN8;
  logic          bias_toggle_select  = 1'b0;
  logic [7:0]    bias_line_count     = 8'h01;
  logic [10:0]   line_width_count    = 11'h003;
  logic [9:0]    frame_line_count    = 10'h001;
  logic [9:0]    pixel_clock_divider = 10'h002;
  logic [1:0]    sync_width_select   = 2'h0;
  logic [1:0]    sync_delay_select   = 2'h0;
  logic [7:0]    line_blank_count    = 8'h00;
  logic [31:0]   red_palette_reg     = 32'h0000_0000;
  logic [31:0]   green_palette_reg   = 32'h0000_0000;
  logic [15:0]   blue_palette_reg    = 16'h0000;
  logic          upper_valid         = 1'b1;
  logic [11:0]   upper_data          = 12'h000;
  logic          lower_valid         = 1'b1;
  logic [11:0]   lower_data          = 12'h000;
  logic          upper_ready, lower_ready, frame_sync_out, line_sync_out;
  logic          pixel_clock_out, ac_bias_out, underrun_pulse;
  logic [7:0]    pixel_data_bus, first_beat, second_beat;
  logic [11:0]   beats_per_line, lines_per_frame;
  int            n_errors   = 0;
  int            num_checks = 0;
  int            underruns  = 0;
  int            overlaps   = 0;

  always #20 clk = ~clk;

  stn_lcd_timing i_dut (.clk(clk), .resetn(resetn), .enable(enable),
    .color_mode(color_mode), .scan_mode(scan_mode), .bias_toggle_select(bias_toggle_select),
    .bias_line_count(bias_line_count), .line_width_count(line_width_count),
    .frame_line_count(frame_line_count), .pixel_clock_divider(pixel_clock_divider),
    .sync_width_select(sync_width_select), .sync_delay_select(sync_delay_select),
    .line_blank_count(line_blank_count), .red_palette_reg(red_palette_reg),
    .green_palette_reg(green_palette_reg), .blue_palette_reg(blue_palette_reg),
    .upper_valid(upper_valid), .upper_ready(upper_ready), .upper_data(upper_data),
    .lower_valid(lower_valid), .lower_ready(lower_ready), .lower_data(lower_data),
    .frame_sync_out(frame_sync_out), .line_sync_out(line_sync_out),
    .pixel_clock_out(pixel_clock_out), .ac_bias_out(ac_bias_out),
    .pixel_data_bus(pixel_data_bus), .underrun_pulse(underrun_pulse));

  stn_panel_model i_panel (.frame_sync_out(frame_sync_out), .line_sync_out(line_sync_out),
    .pixel_clock_out(pixel_clock_out), .pixel_data_bus(pixel_data_bus),
    .first_beat(first_beat), .second_beat(second_beat),
    .beats_per_line(beats_per_line), .lines_per_frame(lines_per_frame));

  // starved beats and a pixel clock that runs into the sync pulse are both faults
  always @(posedge clk) begin
    if (underrun_pulse === 1'b1)
      underruns <= underruns + 1;
    if (line_sync_out === 1'b1 && pixel_clock_out !== 1'b0)
      overlaps <= overlaps + 1;
  end

  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // sample 1 ns after each rising clock edge so registered outputs have settled
  task automatic wait_for(input int sel, input logic lvl, output int n);
    n = 0;
    while (((sel == 0) ? frame_sync_out : line_sync_out) !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 5000) begin
        n_errors++;
        end_of_test();
      end
    end
  endtask

  task automatic run(input stn_color_type cm, input stn_scan_type sm, input logic [9:0] d,
                     input logic [10:0] w, input logic [1:0] ws, input logic [1:0] ds,
                     input logic [7:0] bl, input logic bt, input logic [7:0] bc,
                     input logic [11:0] du, input logic [11:0] dl,
                     input logic [7:0] e0, input logic [7:0] e1);
    int n;
    int wd;
    int p;
    int h;
    int chg;
    logic v;
    logic pv;
    @(posedge clk);
    resetn              <= 1'b0;
    enable              <= 1'b0;
    color_mode          <= cm;
    scan_mode           <= sm;
    pixel_clock_divider <= d;
    line_width_count    <= w;
    sync_width_select   <= ws;
    sync_delay_select   <= ds;
    line_blank_count    <= bl;
    bias_toggle_select  <= bt;
    bias_line_count     <= bc;
    upper_data          <= du;
    lower_data          <= dl;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // let the fifos fill so the first beats are not starved
    repeat (16) @(posedge clk);
    enable <= 1'b1;
    p = (int'(w) + 1) * 2 * int'(d) + (16 << ws) + (16 << ds) + int'(bl) * 8;
    wait_for(0, 1'b1, n);
    wait_for(0, 1'b0, h);
    check("frame sync length", h, p);
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, wd);
    wait_for(1, 1'b1, n);
    check("line sync width", wd, 16 << ws);
    check("line period", wd + n, p);
    wait_for(0, 1'b1, n);
    wait_for(1, 1'b1, n);
    check("lines per frame", lines_per_frame, 2);
    check("beats per line", beats_per_line, int'(w) + 1);
    check("first beat", first_beat, e0);
    check("second beat", second_beat, e1);
    chg = 0;
    pv = 1'b0;
    for (int k = 0; k < 7; k++) begin
      wait_for(1, 1'b0, n);
      wait_for(1, 1'b1, n);
      v = ac_bias_out;
      if (k > 0 && v !== pv)
        chg++;
      pv = v;
    end
    check("bias changes", chg, bt ? 6 / int'(bc) : 3);
  endtask

  // one video case on the 8-bit bus with a slow pixel clock
  task automatic pix(input stn_color_type cm, input logic [11:0] du, input logic [31:0] r,
                     input logic [31:0] g, input logic [15:0] b, input logic [7:0] e);
    @(posedge clk);
    red_palette_reg   <= r;
    green_palette_reg <= g;
    blue_palette_reg  <= b;
    run(cm, STN_SCAN8, 10'h008, 11'h001, 2'h0, 2'h0, 8'h00, 1'b0, 8'h01, du, 12'h000, e, e);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    run(STN_MONO, STN_SCAN8, 10'h002, 11'h003, 2'h0, 2'h0, 8'h00, 1'b0, 8'h01,
        12'h0a5, 12'h000, 8'ha5, 8'ha5);
    run(STN_MONO, STN_SCAN4, 10'h003, 11'h005, 2'h1, 2'h2, 8'h01, 1'b1, 8'h01,
        12'h0a5, 12'h000, 8'h0a, 8'h05);
    run(STN_MONO, STN_DUAL4, 10'h002, 11'h001, 2'h3, 2'h1, 8'h02, 1'b1, 8'h03,
        12'h0a5, 12'h03c, 8'ha3, 8'h5c);
    pix(STN_GRAY16, 12'h00f, 32'h0000_0000, 32'h0000_0000, 16'h0000, 8'hff);
    pix(STN_GRAY16, 12'h000, 32'hffff_ffff, 32'hffff_ffff, 16'hffff, 8'h00);
    pix(STN_GRAY4, 12'h003, 32'h0000_0000, 32'h0000_0000, 16'hf000, 8'hff);
    pix(STN_GRAY4, 12'h003, 32'h0000_0000, 32'h0000_0000, 16'h0fff, 8'h00);
    pix(STN_COL256, 12'h0ff, 32'hf000_0000, 32'hf000_0000, 16'hf000, 8'hff);
    pix(STN_COL256, 12'h0ff, 32'h0fff_ffff, 32'h0fff_ffff, 16'h0fff, 8'h00);
    pix(STN_COL4096, 12'hfff, 32'h0000_0000, 32'h0000_0000, 16'h0000, 8'hff);
    pix(STN_COL4096, 12'h000, 32'hffff_ffff, 32'hffff_ffff, 16'hffff, 8'h00);
    check("underrun pulses", underruns, 0);
    check("pixel clock in sync", overlaps, 0);
    end_of_test();
  end
endmodule
